// File: hw/quad_equalizer_control.sv
// top of the quad equalizer control: pin synchronisers, management writes, four channels
`timescale 1ns/1ps
`include "quad_eq_consts.svh"
module quad_equalizer_control
  import quad_eq_pkg::*;
(
  input  wire logic                        core_clk_in,
  input  wire logic                        resetn_in,
  input  wire logic                        boost_sel_msb_in,
  input  wire logic                        boost_sel_mid_in,
  input  wire logic                        boost_sel_lsb_in,
  input  wire logic                        chan0_enable_in,
  input  wire logic                        chan1_enable_in,
  input  wire logic                        chan2_enable_in,
  input  wire logic                        chan3_enable_in,
  input  wire logic                        force_pin_boost_in,
  input  wire logic                        chan0_sig_present_in,
  input  wire logic                        chan1_sig_present_in,
  input  wire logic                        chan2_sig_present_in,
  input  wire logic                        chan3_sig_present_in,
  input  wire logic                        mgmt_bus_clock_in,
  input  wire logic                        mgmt_chip_select_in,
  input  wire logic                        mgmt_wr_valid_in,
  input  wire logic [`EQ_CHAN_SEL_W-1:0]   mgmt_wr_chan_in,
  input  wire boost_t                      mgmt_wr_boost_in,
  input  wire logic [`EQ_CHAN_SEL_W-1:0]   rd_chan_in,
  output boost_t                           chan0_boost_out,
  output boost_t                           chan1_boost_out,
  output boost_t                           chan2_boost_out,
  output boost_t                           chan3_boost_out,
  output logic                             chan0_active_out,
  output logic                             chan1_active_out,
  output logic                             chan2_active_out,
  output logic                             chan3_active_out,
  output logic                             chan0_sig_detect_out,
  output logic                             chan1_sig_detect_out,
  output logic                             chan2_sig_detect_out,
  output logic                             chan3_sig_detect_out,
  output logic                             boost_from_pins_out,
  output boost_t                           rd_mgmt_boost_out
);
  localparam int NCH = `EQ_NUM_CHAN;

  // reset values of the synchronisers equal the pin pull levels,
  // so a floating strap reads as its pulled level from reset onward
  localparam logic [`EQ_PIN_W-1:0] PIN_RESET = {
    3'h0,                         // write data
    2'h0,                         // write channel
    1'b0,                         // write valid
    1'b0,                         // chip select
    `EQ_MGMT_CLK_PULL,            // management clock
    4'h0,                         // signal present
    `EQ_FORCE_PULL,               // RULE8
    {4{`EQ_ENABLE_PULL}},         // RULE10
    `EQ_BOOST_PULL                // RULE5
  };

  logic [`EQ_PIN_W-1:0] pin_raw;
  logic [`EQ_PIN_W-1:0] pin_meta;
  logic [`EQ_PIN_W-1:0] pin_sync;

  assign pin_raw = {mgmt_wr_boost_in, mgmt_wr_chan_in, mgmt_wr_valid_in, mgmt_chip_select_in,
                    mgmt_bus_clock_in,
                    chan3_sig_present_in, chan2_sig_present_in, chan1_sig_present_in, chan0_sig_present_in,
                    force_pin_boost_in,
                    chan3_enable_in, chan2_enable_in, chan1_enable_in, chan0_enable_in,
                    boost_sel_msb_in, boost_sel_mid_in, boost_sel_lsb_in}; // RULE4

  // two flops per pin; only the second stage is read anywhere
  genvar gi;
  generate
    for (gi = 0; gi < `EQ_PIN_W; gi++) begin : g_sync
      always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          pin_meta[gi] <= PIN_RESET[gi];
          pin_sync[gi] <= PIN_RESET[gi];
        end else begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end
    end
  endgenerate

  boost_t                   pin_boost;
  logic [NCH-1:0]           enable_s;
  logic                     force_s;
  logic [NCH-1:0]           sig_s;
  logic                     mclk_s;
  logic                     cs_s;
  logic                     wvalid_s;
  logic [`EQ_CHAN_SEL_W-1:0] wchan_s;
  boost_t                   wdata_s;

  assign pin_boost = pin_sync[`EQ_POS_BOOST +: `EQ_BOOST_W]; // RULE4
  assign enable_s  = pin_sync[`EQ_POS_ENABLE +: NCH];
  assign force_s   = pin_sync[`EQ_POS_FORCE];
  assign sig_s     = pin_sync[`EQ_POS_SIG +: NCH];
  assign mclk_s    = pin_sync[`EQ_POS_MCLK];
  assign cs_s      = pin_sync[`EQ_POS_CS];
  assign wvalid_s  = pin_sync[`EQ_POS_WVALID];
  assign wchan_s   = pin_sync[`EQ_POS_WCHAN +: `EQ_CHAN_SEL_W];
  assign wdata_s   = pin_sync[`EQ_POS_WDATA +: `EQ_BOOST_W];

  // management clock is oversampled; the host must keep each edge
  // at least three core cycles apart for a write to be seen
  logic gated_mclk;
  logic gated_mclk_q;
  logic mclk_rise;

  assign gated_mclk = mclk_s & cs_s; // RULE13
  assign mclk_rise  = gated_mclk & ~gated_mclk_q;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      gated_mclk_q <= 1'b0;
    end else begin
      gated_mclk_q <= gated_mclk;
    end
  end

  logic wr_take;
  assign wr_take = mclk_rise & wvalid_s & cs_s; // RULE12

  logic [NCH-1:0][`EQ_BOOST_W-1:0] mgmt_boost;

  generate
    for (gi = 0; gi < NCH; gi++) begin : g_mreg
      always_ff @(posedge core_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          mgmt_boost[gi] <= `EQ_MGMT_BOOST_RST;
        end else if (wr_take && wchan_s == gi[`EQ_CHAN_SEL_W-1:0]) begin
          mgmt_boost[gi] <= wdata_s; // RULE3 RULE12
        end
      end
    end
  endgenerate

  // readback select comes from logic on this clock, so it skips the synchronisers
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_mgmt_boost_out <= `EQ_MGMT_BOOST_RST;
    end else begin
      rd_mgmt_boost_out <= mgmt_boost[rd_chan_in];
    end
  end

  assign boost_from_pins_out = force_s; // RULE6 RULE7

  boost_t         boost_v  [NCH];
  logic [NCH-1:0] active_v;
  logic [NCH-1:0] detect_v;

  generate
    for (gi = 0; gi < NCH; gi++) begin : g_chan
      eq_channel u_chan (
        .core_clk_in    (core_clk_in),
        .resetn_in      (resetn_in),
        .enable_in      (enable_s[gi]),
        .force_pin_in   (force_s),
        .pin_boost_in   (pin_boost),
        .mgmt_boost_in  (mgmt_boost[gi]),
        .sig_present_in (sig_s[gi]),
        .boost_out      (boost_v[gi]),
        .active_out     (active_v[gi]),
        .sig_detect_out (detect_v[gi])
      ); // RULE1 RULE2
    end
  endgenerate

  assign chan0_boost_out      = boost_v[0];
  assign chan1_boost_out      = boost_v[1];
  assign chan2_boost_out      = boost_v[2];
  assign chan3_boost_out      = boost_v[3];
  assign chan0_active_out     = active_v[0];
  assign chan1_active_out     = active_v[1];
  assign chan2_active_out     = active_v[2];
  assign chan3_active_out     = active_v[3];
  assign chan0_sig_detect_out = detect_v[0];
  assign chan1_sig_detect_out = detect_v[1];
  assign chan2_sig_detect_out = detect_v[2];
  assign chan3_sig_detect_out = detect_v[3];

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  property p_cs_gate;
    !cs_s |=> mgmt_boost == $past(mgmt_boost);
  endproperty
  a_cs_gate: assert property (p_cs_gate) else $error("management edge seen without chip select"); // RULE13

  property p_no_write_without_edge;
    !wr_take |=> mgmt_boost == $past(mgmt_boost);
  endproperty
  a_no_write_without_edge: assert property (p_no_write_without_edge) else $error("register changed without write"); // RULE12

  property p_write_lands;
    wr_take |=> mgmt_boost[$past(wchan_s)] == $past(wdata_s);
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("management write lost"); // RULE3

  property p_pin_to_chan0;
    force_s && enable_s[0] |=> chan0_boost_out == $past(pin_boost);
  endproperty
  a_pin_to_chan0: assert property (p_pin_to_chan0) else $error("pin code not on channel 0"); // RULE4

  property p_enable_path;
    $fell(enable_s[1]) |=> !chan1_active_out;
  endproperty
  a_enable_path: assert property (p_enable_path) else $error("channel 1 standby late"); // RULE9

  property p_mgmt_to_chan2;
    wr_take && wchan_s == 2'h2 ##1 !force_s && enable_s[2] |=> chan2_boost_out == $past(wdata_s, 2);
  endproperty
  a_mgmt_to_chan2: assert property (p_mgmt_to_chan2) else $error("management code not on channel 2"); // RULE7

  property p_readback;
    wr_take && wchan_s == rd_chan_in ##1 $stable(rd_chan_in) |=> rd_mgmt_boost_out == $past(wdata_s, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("readback lags the written code"); // RULE3

  property p_standby_detect3;
    !enable_s[3] |=> !chan3_sig_detect_out;
  endproperty
  a_standby_detect3: assert property (p_standby_detect3) else $error("channel 3 detect high in standby"); // RULE14
endmodule // quad_equalizer_control

// File: hw/quad_eq_consts.svh
// constants for the quad equalizer control logic
// How it works
// RULE1: four channels, each own enable and detect
// RULE2: eight boost levels as a 3-bit code
// RULE3: boost from shared pins or per-channel management
// RULE4: three select pins form the pin boost code
// RULE5: unconnected select pins default to code 100
// RULE6: force input high selects pin boost
// RULE7: force input low selects management boost
// RULE8: unconnected force input defaults high
// RULE9: enable high runs channel, low means standby
// RULE10: unconnected enable defaults high, channel active
// RULE11: detect output high while signal present
// RULE12: management writes accepted only with chip select
// RULE13: chip select gates the management clock
// RULE14: standby forces detect low, holds boost
`ifndef QUAD_EQ_CONSTS_SVH
`define QUAD_EQ_CONSTS_SVH
`define EQ_NUM_CHAN        4
`define EQ_BOOST_W         3
`define EQ_CHAN_SEL_W      2
`define EQ_BOOST_PULL      3'h4
`define EQ_FORCE_PULL      1'b1
`define EQ_ENABLE_PULL     1'b1
`define EQ_MGMT_CLK_PULL   1'b1
`define EQ_MGMT_BOOST_RST  3'h4
// synchroniser vector layout
`define EQ_PIN_W           20
`define EQ_POS_BOOST       0
`define EQ_POS_ENABLE      3
`define EQ_POS_FORCE       7
`define EQ_POS_SIG         8
`define EQ_POS_MCLK        12
`define EQ_POS_CS          13
`define EQ_POS_WVALID      14
`define EQ_POS_WCHAN       15
`define EQ_POS_WDATA       17
`endif

// File: hw/quad_eq_pkg.sv
// shared types for the quad equalizer control logic
package quad_eq_pkg;
  typedef logic [2:0] boost_t;
  typedef enum logic [0:0] {
    SRC_MGMT = 1'b0,
    SRC_PIN  = 1'b1
  } boost_src_e;
endpackage

// File: hw/eq_channel.sv
// one equalizer channel: enable, boost selection and signal detect
`timescale 1ns/1ps
`include "quad_eq_consts.svh"
module eq_channel
  import quad_eq_pkg::*;
(
  input  wire logic   core_clk_in,
  input  wire logic   resetn_in,
  input  wire logic   enable_in,
  input  wire logic   force_pin_in,
  input  wire boost_t pin_boost_in,
  input  wire boost_t mgmt_boost_in,
  input  wire logic   sig_present_in,
  output boost_t      boost_out,
  output logic        active_out,
  output logic        sig_detect_out
);
  boost_src_e src;
  assign src = force_pin_in ? SRC_PIN : SRC_MGMT;

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      active_out <= `EQ_ENABLE_PULL;
    end else begin
      active_out <= enable_in; // RULE9
    end
  end

  // standby freezes the code; it reloads from the selected source on the same edge that active_out rises
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      boost_out <= `EQ_BOOST_PULL;
    end else if (enable_in) begin // RULE14
      case (src)
        SRC_PIN:  boost_out <= pin_boost_in; // RULE6
        SRC_MGMT: boost_out <= mgmt_boost_in; // RULE7
        default:  boost_out <= pin_boost_in;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sig_detect_out <= 1'b0;
    end else begin
      sig_detect_out <= sig_present_in & enable_in; // RULE11 RULE14
    end
  end

  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  property p_pin_boost;
    enable_in && force_pin_in |=> boost_out == $past(pin_boost_in);
  endproperty
  a_pin_boost: assert property (p_pin_boost) else $error("pin boost not applied"); // RULE6

  property p_mgmt_boost;
    enable_in && !force_pin_in |=> boost_out == $past(mgmt_boost_in);
  endproperty
  a_mgmt_boost: assert property (p_mgmt_boost) else $error("management boost not applied"); // RULE7

  property p_standby_hold;
    !enable_in [*2] |-> $stable(boost_out);
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("boost moved in standby"); // RULE14

  property p_detect;
    enable_in && sig_present_in |=> sig_detect_out;
  endproperty
  a_detect: assert property (p_detect) else $error("signal detect missing"); // RULE11

  property p_standby_detect;
    !enable_in |=> !sig_detect_out && !active_out;
  endproperty
  a_standby_detect: assert property (p_standby_detect) else $error("detect high in standby"); // RULE9
endmodule // eq_channel

// File: test/mgmt_host_model.sv
// management bus host model: strobe-style writes on a gated clock
`timescale 1ns/1ps
module mgmt_host_model
  import quad_eq_pkg::*;
(
  input  wire logic       core_clk_in,
  input  wire logic       start_in,
  input  wire logic       cs_req_in,
  input  wire logic [1:0] chan_in,
  input  wire boost_t     boost_in,
  output logic            mgmt_bus_clock_out,
  output logic            mgmt_chip_select_out,
  output logic            mgmt_wr_valid_out,
  output logic [1:0]      mgmt_wr_chan_out,
  output boost_t          mgmt_wr_boost_out,
  output logic            done_out
);
  initial begin
    mgmt_bus_clock_out   = 1'b1;
    mgmt_chip_select_out = 1'b0;
    mgmt_wr_valid_out    = 1'b0;
    mgmt_wr_chan_out     = 2'h0;
    mgmt_wr_boost_out    = 3'h0;
    done_out             = 1'b0;
  end
  // clock idles high like its pull-up and runs only inside a write
  always begin
    @(posedge core_clk_in iff start_in);
    #2 mgmt_bus_clock_out = 1'b0;
    repeat (3) @(posedge core_clk_in);
    // select rises only while the clock is low, else the gated clock would show a false edge
    #2 mgmt_chip_select_out = cs_req_in;
    mgmt_wr_valid_out = 1'b1;
    mgmt_wr_chan_out  = chan_in;
    mgmt_wr_boost_out = boost_in;
    repeat (3) @(posedge core_clk_in);
    #2 mgmt_bus_clock_out = 1'b1;
    repeat (4) @(posedge core_clk_in);
    // released lines show the inverse so stale values cannot pass
    #2 mgmt_chip_select_out = 1'b0;
    mgmt_wr_valid_out = 1'b0;
    mgmt_wr_chan_out  = ~mgmt_wr_chan_out;
    mgmt_wr_boost_out = ~mgmt_wr_boost_out;
    done_out          = 1'b1;
    @(posedge core_clk_in);
    #2 done_out = 1'b0;
  end
endmodule // mgmt_host_model

// File: test/tb_top.sv
// self-checking bench for the quad equalizer control
`timescale 1ns/1ps
`include "quad_eq_consts.svh"
module tb_top
  import quad_eq_pkg::*;
;
  typedef struct packed {
    logic       force_pin;
    boost_t     strap;
    logic [3:0] en;
    logic [3:0] sig;
    boost_t     exp;
  } row_s;
  logic       core_clk = 1'b0;
  logic       resetn = 1'b0;
  boost_t     strap = 3'h4;
  logic [3:0] en = 4'hf;
  logic       force_pin = 1'b1;
  logic [3:0] sig = 4'h0;
  logic [1:0] rd_chan = 2'h0;
  logic       start = 1'b0, cs_req = 1'b0, done;
  logic [1:0] wr_chan = 2'h0, m_chan;
  boost_t     wr_data = 3'h0, m_boost, rd_boost;
  logic       m_clk, m_cs, m_valid, from_pins;
  boost_t     bo [4];
  logic [3:0] act, det;
  row_s       rows [12];
  int         mismatches = 0, checks = 0, cycles = 0;

  always #12.5 core_clk = ~core_clk;

  quad_equalizer_control quad_equalizer_control_i (
    .core_clk_in(core_clk), .resetn_in(resetn),
    .boost_sel_msb_in(strap[2]), .boost_sel_mid_in(strap[1]), .boost_sel_lsb_in(strap[0]),
    .chan0_enable_in(en[0]), .chan1_enable_in(en[1]), .chan2_enable_in(en[2]), .chan3_enable_in(en[3]),
    .force_pin_boost_in(force_pin),
    .chan0_sig_present_in(sig[0]), .chan1_sig_present_in(sig[1]),
    .chan2_sig_present_in(sig[2]), .chan3_sig_present_in(sig[3]),
    .mgmt_bus_clock_in(m_clk), .mgmt_chip_select_in(m_cs), .mgmt_wr_valid_in(m_valid),
    .mgmt_wr_chan_in(m_chan), .mgmt_wr_boost_in(m_boost), .rd_chan_in(rd_chan),
    .chan0_boost_out(bo[0]), .chan1_boost_out(bo[1]), .chan2_boost_out(bo[2]), .chan3_boost_out(bo[3]),
    .chan0_active_out(act[0]), .chan1_active_out(act[1]), .chan2_active_out(act[2]),
    .chan3_active_out(act[3]),
    .chan0_sig_detect_out(det[0]), .chan1_sig_detect_out(det[1]), .chan2_sig_detect_out(det[2]),
    .chan3_sig_detect_out(det[3]),
    .boost_from_pins_out(from_pins), .rd_mgmt_boost_out(rd_boost));

  mgmt_host_model mgmt_host_model_i (
    .core_clk_in(core_clk), .start_in(start), .cs_req_in(cs_req), .chan_in(wr_chan), .boost_in(wr_data),
    .mgmt_bus_clock_out(m_clk), .mgmt_chip_select_out(m_cs), .mgmt_wr_valid_out(m_valid),
    .mgmt_wr_chan_out(m_chan), .mgmt_wr_boost_out(m_boost), .done_out(done));

  task automatic report_and_stop();
    if (mismatches == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch; the run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic check_boost(input string what, input boost_t exp, input boost_t got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask

  // inputs always change 2 ns after the rising edge
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask

  task automatic mgmt_write(input logic cs, input logic [1:0] ch, input boost_t d);
    int n;
    cs_req = cs;
    wr_chan = ch;
    wr_data = d;
    start = 1'b1;
    step(1);
    start = 1'b0;
    for (n = 0; n < 40 && done !== 1'b1; n++) @(posedge core_clk);
    check_bit("write done", 1'b1, done);
    step(4);
  endtask

  initial begin
    for (int c = 0; c < 8; c++) begin
      rows[c] = '{1'b1, boost_t'(c), 4'hf, 4'(c * 3), boost_t'(c)};
    end
    // row 8 puts all channels in standby while the straps change: boost must stay frozen
    rows[8]  = '{1'b1, 3'h3, 4'h0, 4'hf, 3'h7};
    rows[9]  = '{1'b1, 3'h3, 4'h6, 4'hf, 3'h3};
    rows[10] = '{1'b1, 3'h3, 4'h9, 4'ha, 3'h3};
    rows[11] = '{1'b0, 3'h1, 4'hf, 4'hf, 3'h4};
    step(3);
    for (int i = 0; i < 4; i++) begin
      check_boost("reset boost", 3'h4, bo[i]);
      check_bit("reset active", 1'b1, act[i]);
      check_bit("reset detect", 1'b0, det[i]);
    end
    check_bit("reset from pins", 1'b1, from_pins);
    check_boost("reset readback", 3'h4, rd_boost);
    step(2);
    resetn = 1'b1;
    for (int r = 0; r < 12; r++) begin
      {force_pin, strap, en, sig} = {rows[r].force_pin, rows[r].strap, rows[r].en, rows[r].sig};
      step(4);
      check_bit("from pins", rows[r].force_pin, from_pins);
      for (int i = 0; i < 4; i++) begin
        if (rows[r].en[i] | r == 8) begin
          check_boost("boost", rows[r].exp, bo[i]);
        end
        check_bit("active", rows[r].en[i], act[i]);
        check_bit("detect", rows[r].en[i] & rows[r].sig[i], det[i]);
      end
    end
    // write with select low must leave channel 0 at its reset code
    mgmt_write(1'b0, 2'h0, 3'h6);
    check_boost("refused write", 3'h4, bo[0]);
    for (int i = 0; i < 4; i++) begin
      mgmt_write(1'b1, 2'(i), boost_t'(i + 1));
    end
    for (int i = 0; i < 4; i++) begin
      check_boost("mgmt boost", boost_t'(i + 1), bo[i]);
      rd_chan = 2'(i);
      step(2);
      check_boost("readback", boost_t'(i + 1), rd_boost);
    end
    en[2] = 1'b0;
    step(4);
    mgmt_write(1'b1, 2'h2, 3'h7);
    check_boost("standby boost", 3'h3, bo[2]);
    check_bit("standby detect", 1'b0, det[2]);
    check_boost("other channel", 3'h2, bo[1]);
    en[2] = 1'b1;
    step(4);
    check_boost("resumed boost", 3'h7, bo[2]);
    // mid-run reset must drop the written codes back to 100
    resetn = 1'b0;
    rd_chan = 2'h2;
    step(2);
    check_boost("reset mgmt readback", 3'h4, rd_boost);
    check_boost("reset boost", 3'h4, bo[2]);
    resetn = 1'b1;
    step(4);
    check_boost("mgmt after reset", 3'h4, bo[2]);
    report_and_stop();
  end
endmodule // tb_top
